// ---- pls_cfg.svh ----
// Constants for the power loss restart sequencer.
`ifndef PLS_CFG_SVH
`define PLS_CFG_SVH
`define PLS_ADR_CTRL      8'h00
`define PLS_ADR_START     8'h04
`define PLS_ADR_OUTAGE    8'h08
`define PLS_ADR_STATUS    8'h0C
`define PLS_ADR_INTSTAT   8'h10
`define PLS_ADR_INTMASK   8'h14
`define PLS_ADR_LATCHED   8'h18
`define PLS_CTRL_MODE     2:0
`define PLS_CTRL_SRC      5:4
`define PLS_CTRL_SEARCH   8
`define PLS_CTRL_ACLR     16
`define PLS_CTRL_MASK     32'h0000_0137
`define PLS_START_MASK    32'h0000_FFFF
`define PLS_OUTAGE_MASK   32'h0000_03FF
`define PLS_CTRL_RST      32'h0000_0000
`define PLS_START_RST     32'h0000_0000
`define PLS_OUTAGE_RST    32'h0000_03E7
`define PLS_MODE_TRIP     3'h0
`define PLS_MODE_TRIPREC  3'h1
`define PLS_MODE_RESUME   3'h4
`define PLS_MODE_START    3'h5
`define PLS_SRC_FIX_FWD   2'h2
`define PLS_SRC_FIX_REV   2'h3
`define PLS_OUTAGE_NOLIM  10'h3E7
`define PLS_EV_OUTAGE     0
`define PLS_EV_ALARM      1
`define PLS_EV_RESTART    2
`define PLS_EV_CANCEL     3
`define PLS_EV_W          4
`define PLS_CLK_HZ        20000000
`define PLS_TICK_MS       100
`define PLS_TICK_CYCLES   (`PLS_CLK_HZ / 1000 * `PLS_TICK_MS)
`define PLS_TICK_W        22
`define PLS_WAIT_MS       2000
`define PLS_WAIT_TICKS    5'(`PLS_WAIT_MS / `PLS_TICK_MS)
`endif

// ---- pls_pkg.sv ----
// Types shared by the power loss restart sequencer.
package pls_pkg;
	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_TRIP,
		ST_PENDING,
		ST_CHARGE,
		ST_WAIT
	} pls_state_e;
	typedef enum logic [1:0] {
		FSEL_NORMAL,
		FSEL_LATCHED,
		FSEL_START
	} pls_fsel_e;
endpackage : pls_pkg

// ---- pls_restart_seq.sv ----
// Power loss restart sequencer with a classic Wishbone register slave.
// Summary of operation
// R1 - Mode 0: undervoltage while running raises alarm at once and cuts output.
// R2 - Mode 1: cut output without alarm; alarm when power returns, output stays off.
// R3 - Mode 4: latch running frequency at undervoltage, then cut output.
// R4 - Mode 4: run command at power return resumes at the latched frequency.
// R5 - Mode 5: restart at the starting frequency setting after power and run command.
// R6 - Failure recognised only for undervoltage while output runs; shallow dips ignored.
// R7 - Failure enters pending restart; returned power passes charging before ready.
// R8 - When ready, wait up to 2 s for run command, then restart per mode.
// R9 - No run command within 2 s cancels pending restart; normal start follows.
// R10 - Source 2 or 3 keeps run state and restarts as soon as ready.
// R11 - Keypad run with terminal direction, source 0, still uses the 2 s wait.
// R12 - Outside controller should reassert run within 2 s or latch it.
// R13 - Restart may request idle speed search of the coasting motor.
// R14 - Allowable outage time expiry cancels the wait, even inside 2 s.
// R15 - Coast stop command during failure cancels pending restart.
// R16 - The 2 s window counts timebase ticks, cleared on entering ready.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`include "pls_cfg.svh"
module pls_restart_seq #(
	parameter int TICK_CYCLES = `PLS_TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Power stage and command inputs.
	input  wire logic        dc_undervolt_i,
	input  wire logic        charge_done_i,
	input  wire logic        dc_restart_low_i,
	input  wire logic [15:0] output_freq_i,
	input  wire logic        forward_run_cmd_i,
	input  wire logic        reverse_run_cmd_i,
	input  wire logic        coast_stop_cmd_i,
	// Drive control outputs.
	output logic             out_en_o,
	output logic      [1:0]  freq_sel_o,
	output logic      [15:0] restart_freq_o,
	output logic             restart_o,
	output logic             idle_search_o,
	output logic             uv_alarm_o,
	output logic             irq_o
);
	// ****************************************
	// Declarations.
	// ****************************************
	function automatic logic [31:0] pls_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return ((old_v & ~lanes) | (new_v & lanes)) & mask;
	endfunction : pls_merge
	logic [31:0] ctrl, next_ctrl, start_frq, next_start_frq, outage, next_outage_reg;
	logic [31:0] next_rdat;
	logic        next_ack;
	logic [`PLS_EV_W-1:0] int_stat, next_int_stat, int_mask, next_int_mask, ev;
	logic        wr, alarm_clr;
	pls_pkg::pls_state_e state, next_state;
	pls_pkg::pls_fsel_e  fsel, next_fsel;
	logic        out_en, next_out_en, hold, next_hold, alarm, next_alarm;
	logic        next_restart, next_search;
	logic [15:0] latched, next_latched, rfreq, next_rfreq;
	logic [4:0]  win_cnt, next_win;
	logic [9:0]  outage_cnt, next_outage;
	logic [`PLS_TICK_W-1:0] tick_cnt, next_tick_cnt;
	logic        tick, run_cmd, retained, recog, expired, cancel;
	logic [2:0]  mode;
	assign mode = ctrl[`PLS_CTRL_MODE];
	assign run_cmd = forward_run_cmd_i | reverse_run_cmd_i;
	assign retained = (ctrl[`PLS_CTRL_SRC] == `PLS_SRC_FIX_FWD) ||
		(ctrl[`PLS_CTRL_SRC] == `PLS_SRC_FIX_REV); // [R10] [R11]
	assign recog = (state == pls_pkg::ST_NORMAL) && dc_undervolt_i && out_en; // [R6]
	assign expired = (outage[9:0] == `PLS_OUTAGE_NOLIM) ? dc_restart_low_i :
		(outage_cnt >= outage[9:0]); // [R14]
	assign cancel = coast_stop_cmd_i | expired; // [R14] [R15]
	assign tick = (tick_cnt == `PLS_TICK_W'(TICK_CYCLES - 1)); // [R16]

	// ****************************************
	// Register bus.
	// ****************************************
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign alarm_clr = wr && (wb_adr_i == `PLS_ADR_CTRL) && wb_sel_i[2] && wb_dat_i[`PLS_CTRL_ACLR];
	always_comb begin
		next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_rdat = wb_dat_o;
		next_ctrl = ctrl;
		next_start_frq = start_frq;
		next_outage_reg = outage;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		if (next_ack && !wb_we_i) begin
			unique case (wb_adr_i)
				`PLS_ADR_CTRL:    next_rdat = ctrl;
				`PLS_ADR_START:   next_rdat = start_frq;
				`PLS_ADR_OUTAGE:  next_rdat = outage;
				`PLS_ADR_STATUS:  next_rdat = {25'h0, fsel, alarm, out_en, state};
				`PLS_ADR_INTSTAT: next_rdat = {28'h0, int_stat};
				`PLS_ADR_INTMASK: next_rdat = {28'h0, int_mask};
				`PLS_ADR_LATCHED: next_rdat = {16'h0, latched};
				default:          next_rdat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (wb_adr_i)
				`PLS_ADR_CTRL:    next_ctrl = pls_merge(ctrl, wb_dat_i, wb_sel_i, `PLS_CTRL_MASK);
				`PLS_ADR_START:   next_start_frq = pls_merge(start_frq, wb_dat_i, wb_sel_i,
					`PLS_START_MASK);
				`PLS_ADR_OUTAGE:  next_outage_reg = pls_merge(outage, wb_dat_i, wb_sel_i,
					`PLS_OUTAGE_MASK);
				`PLS_ADR_INTSTAT: begin
					if (wb_sel_i[0]) begin
						next_int_stat = int_stat & ~wb_dat_i[`PLS_EV_W-1:0];
					end
				end
				`PLS_ADR_INTMASK: begin
					if (wb_sel_i[0]) begin
						next_int_mask = wb_dat_i[`PLS_EV_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		next_int_stat = next_int_stat | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			ctrl <= `PLS_CTRL_RST;
			start_frq <= `PLS_START_RST;
			outage <= `PLS_OUTAGE_RST;
			int_stat <= '0;
			int_mask <= '0;
		end else begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_rdat;
			ctrl <= next_ctrl;
			start_frq <= next_start_frq;
			outage <= next_outage_reg;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
		end
	end

	assign irq_o = |(int_stat & int_mask);
	// ****************************************
	// Restart sequencer.
	// ****************************************
	always_comb begin
		next_tick_cnt = tick ? '0 : tick_cnt + `PLS_TICK_W'(1);
		next_state = state;
		next_out_en = out_en;
		next_hold = hold;
		next_alarm = alarm;
		next_latched = latched;
		next_fsel = fsel;
		next_rfreq = rfreq;
		next_restart = 1'b0;
		next_search = 1'b0;
		next_win = win_cnt;
		next_outage = outage_cnt;
		ev = '0;
		if (tick && outage_cnt != 10'h3FF) begin
			next_outage = outage_cnt + 10'h001;
		end
		unique case (state)
			pls_pkg::ST_NORMAL: begin
				if (recog) begin
					next_out_en = 1'b0;
					next_hold = 1'b0;
					next_outage = 10'h000;
					ev[`PLS_EV_OUTAGE] = 1'b1;
					if (mode == `PLS_MODE_RESUME) begin
						next_latched = output_freq_i; // [R3]
						next_state = pls_pkg::ST_PENDING; // [R7]
					end else if (mode == `PLS_MODE_START || mode == `PLS_MODE_TRIPREC) begin
						next_state = pls_pkg::ST_PENDING; // [R2] [R7]
					end else begin
						next_alarm = 1'b1; // [R1]
						ev[`PLS_EV_ALARM] = 1'b1;
						next_state = pls_pkg::ST_TRIP;
					end
				end else begin
					if (coast_stop_cmd_i) begin
						next_hold = 1'b0;
					end
					next_out_en = (run_cmd | hold) & ~coast_stop_cmd_i & ~dc_undervolt_i & ~alarm;
					if (!next_out_en) begin
						next_fsel = pls_pkg::FSEL_NORMAL; // [R9] [R15]
					end
				end
			end
			pls_pkg::ST_TRIP: begin
				next_out_en = 1'b0;
				if (alarm_clr) begin
					next_alarm = 1'b0;
					next_state = pls_pkg::ST_NORMAL;
				end
			end
			pls_pkg::ST_PENDING: begin
				if (!dc_undervolt_i && mode == `PLS_MODE_TRIPREC) begin
					next_alarm = 1'b1; // [R2]
					ev[`PLS_EV_ALARM] = 1'b1;
					next_state = pls_pkg::ST_TRIP;
				end else if (cancel) begin
					ev[`PLS_EV_CANCEL] = 1'b1; // [R14] [R15]
					next_state = pls_pkg::ST_NORMAL;
				end else if (!dc_undervolt_i) begin
					next_state = pls_pkg::ST_CHARGE; // [R7]
				end
			end
			pls_pkg::ST_CHARGE: begin
				if (dc_undervolt_i) begin
					next_state = pls_pkg::ST_PENDING;
				end else if (cancel) begin
					ev[`PLS_EV_CANCEL] = 1'b1; // [R14] [R15]
					next_state = pls_pkg::ST_NORMAL;
				end else if (charge_done_i) begin
					next_win = 5'h00; // [R16]
					next_state = pls_pkg::ST_WAIT; // [R7]
				end
			end
			pls_pkg::ST_WAIT: begin
				if (dc_undervolt_i) begin
					next_state = pls_pkg::ST_PENDING;
				end else if (cancel) begin
					ev[`PLS_EV_CANCEL] = 1'b1; // [R14] [R15]
					next_state = pls_pkg::ST_NORMAL;
				end else if (run_cmd || retained) begin
					next_out_en = 1'b1; // [R8] [R10]
					next_hold = retained;
					next_restart = 1'b1;
					next_search = ctrl[`PLS_CTRL_SEARCH]; // [R13]
					ev[`PLS_EV_RESTART] = 1'b1;
					if (mode == `PLS_MODE_RESUME) begin
						next_fsel = pls_pkg::FSEL_LATCHED; // [R4]
						next_rfreq = latched;
					end else begin
						next_fsel = pls_pkg::FSEL_START; // [R5]
						next_rfreq = start_frq[15:0];
					end
					next_state = pls_pkg::ST_NORMAL;
				end else if (tick) begin
					if (win_cnt == `PLS_WAIT_TICKS - 5'h01) begin
						ev[`PLS_EV_CANCEL] = 1'b1; // [R9] [R11]
						next_state = pls_pkg::ST_NORMAL;
					end else begin
						next_win = win_cnt + 5'h01; // [R16]
					end
				end
			end
			default: next_state = pls_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= '0;
			state <= pls_pkg::ST_NORMAL;
			out_en <= 1'b0;
			hold <= 1'b0;
			alarm <= 1'b0;
			latched <= 16'h0000;
			fsel <= pls_pkg::FSEL_NORMAL;
			rfreq <= 16'h0000;
			restart_o <= 1'b0;
			idle_search_o <= 1'b0;
			win_cnt <= 5'h00;
			outage_cnt <= 10'h000;
		end else begin
			tick_cnt <= next_tick_cnt;
			state <= next_state;
			out_en <= next_out_en;
			hold <= next_hold;
			alarm <= next_alarm;
			latched <= next_latched;
			fsel <= next_fsel;
			rfreq <= next_rfreq;
			restart_o <= next_restart;
			idle_search_o <= next_search;
			win_cnt <= next_win;
			outage_cnt <= next_outage;
		end
	end

	assign out_en_o = out_en;
	assign freq_sel_o = fsel;
	assign restart_freq_o = rfreq;
	assign uv_alarm_o = alarm;

	// ****************************************
	// Assertions.
	// ****************************************
	trip_alarm_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		recog && mode == `PLS_MODE_TRIP |=> uv_alarm_o && !out_en_o && state == pls_pkg::ST_TRIP)
		else $error("Mode 0 failure did not trip.");
	quiet_cut_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		(recog && mode == `PLS_MODE_TRIPREC |=> !uv_alarm_o && !out_en_o) and
		(state == pls_pkg::ST_PENDING && mode == `PLS_MODE_TRIPREC && !dc_undervolt_i
		|=> uv_alarm_o && !out_en_o))
		else $error("Mode 1 alarm timing wrong.");
	freq_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		recog && mode == `PLS_MODE_RESUME |=> latched == $past(output_freq_i) && !out_en_o)
		else $error("Frequency not latched on failure.");
	resume_freq_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		state == pls_pkg::ST_WAIT && run_cmd && !cancel && !dc_undervolt_i &&
		mode == `PLS_MODE_RESUME |=> out_en_o && restart_o && restart_freq_o == latched &&
		freq_sel_o == pls_pkg::FSEL_LATCHED)
		else $error("Resume not at latched frequency.");
	start_freq_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		state == pls_pkg::ST_WAIT && run_cmd && !cancel && !dc_undervolt_i &&
		mode == `PLS_MODE_START |=> out_en_o && restart_freq_o == $past(start_frq[15:0]) &&
		freq_sel_o == pls_pkg::FSEL_START)
		else $error("Restart not at starting frequency.");
	dip_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		state == pls_pkg::ST_NORMAL && !(dc_undervolt_i && out_en_o) && !int_stat[`PLS_EV_OUTAGE]
		|=> state == pls_pkg::ST_NORMAL && !int_stat[`PLS_EV_OUTAGE])
		else $error("Failure recognised without cause.");
	charge_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		$rose(state == pls_pkg::ST_WAIT) |-> $past(state) == pls_pkg::ST_CHARGE && win_cnt == 5'h00)
		else $error("Ready reached without charging.");
	window_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		state == pls_pkg::ST_WAIT && tick && win_cnt == `PLS_WAIT_TICKS - 5'h01 && !run_cmd &&
		!retained && !cancel && !dc_undervolt_i |=> state == pls_pkg::ST_NORMAL && !out_en_o)
		else $error("Window expiry did not cancel.");
	fixed_dir_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		state == pls_pkg::ST_WAIT && retained && !cancel && !dc_undervolt_i |=> out_en_o ##1 out_en_o
		|| coast_stop_cmd_i || dc_undervolt_i || $past(coast_stop_cmd_i) || $past(dc_undervolt_i))
		else $error("Retained run did not restart.");
	cancel_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14] [R15]
		(state == pls_pkg::ST_CHARGE || state == pls_pkg::ST_WAIT) && cancel && !dc_undervolt_i
		|=> state == pls_pkg::ST_NORMAL && int_stat[`PLS_EV_CANCEL])
		else $error("Cancel did not leave pending restart.");
endmodule : pls_restart_seq

// ---- pls_src_model.sv ----
// Behavioural model of the run command source and the DC link monitor.
module pls_src_model (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Scenario control.
	input  wire logic       run_want_i,
	input  wire logic       rev_i,
	input  wire logic       power_ok_i,
	input  wire logic [7:0] rerun_dly_i,
	// Drive side.
	output logic            dc_undervolt_o,
	output logic            charge_done_o,
	output logic            dc_restart_low_o,
	output logic            forward_run_cmd_o,
	output logic            reverse_run_cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Charging delay and run command recovery.
	// ****************************************
	logic [7:0] chg;
	logic       lost;
	always_ff @(posedge clk_i) begin
		if (rst_i || !power_ok_i) begin
			chg <= 8'h00;
		end else if (chg != 8'hFF) begin
			chg <= chg + 8'h01;
		end
		if (rst_i) begin
			lost <= 1'b0;
		end else if (!power_ok_i) begin
			lost <= 1'b1;
		end else if (!run_want_i) begin
			lost <= 1'b0;
		end else if (rerun_dly_i != 8'hFF && chg == 8'h10 + rerun_dly_i) begin
			lost <= 1'b0;
		end
	end
	assign dc_undervolt_o    = !power_ok_i;
	assign charge_done_o     = (chg >= 8'h10);
	assign dc_restart_low_o  = 1'b0;
	assign forward_run_cmd_o = run_want_i && !lost && !rev_i;
	assign reverse_run_cmd_o = run_want_i && !lost && rev_i;
endmodule : pls_src_model

// ---- pls_restart_seq_tb.sv ----
// Self-checking testbench of the power loss restart sequencer.
`include "pls_cfg.svh"
module pls_restart_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals, design and partner.
	// ****************************************
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h0, wb_dat_o, rd;
	logic        wb_ack_o, uv, chg_ok, rlow, forward_run_cmd, reverse_run_cmd, coast = 1'b0;
	logic        run_want = 1'b0, dir = 1'b0, pwr = 1'b1;
	logic [7:0]  dly = 8'hFF;
	logic [15:0] ofreq = 16'h0000, rfreq, cap_f;
	logic        out_en, ridle, alarm, irq, rs, cap_i;
	logic [1:0]  fsel, cap_s;
	int          errors = 0, checks = 0, rcnt = 0;
	always #25 clk_i = ~clk_i;
	pls_restart_seq #(.TICK_CYCLES(10)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .dc_undervolt_i(uv), .charge_done_i(chg_ok),
		.dc_restart_low_i(rlow), .output_freq_i(ofreq), .forward_run_cmd_i(forward_run_cmd),
		.reverse_run_cmd_i(reverse_run_cmd), .coast_stop_cmd_i(coast), .out_en_o(out_en),
		.freq_sel_o(fsel), .restart_freq_o(rfreq), .restart_o(rs),
		.idle_search_o(ridle), .uv_alarm_o(alarm), .irq_o(irq));
	pls_src_model MODEL (
		.clk_i(clk_i), .rst_i(rst_i), .run_want_i(run_want), .rev_i(dir), .power_ok_i(pwr),
		.rerun_dly_i(dly), .dc_undervolt_o(uv), .charge_done_o(chg_ok),
		.dc_restart_low_o(rlow), .forward_run_cmd_o(forward_run_cmd), .reverse_run_cmd_o(reverse_run_cmd));
	always @(posedge clk_i) begin
		if (rs === 1'b1) begin
			rcnt <= rcnt + 1;
			cap_s <= fsel;
			cap_f <= rfreq;
			cap_i <= ridle;
		end
	end
	// ****************************************
	// Tasks.
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [31:0] exp_int(input logic [2:0] m, input logic ex);
		return {28'h0, !ex && m > 3'h1, ex, m < 3'h2, 1'b1};
	endfunction : exp_int
	task automatic final_report();
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic outage(input logic [2:0] m, input logic [1:0] s, input logic [7:0] d,
			input logic cs, input logic [9:0] lim, input logic ex);
		logic [15:0] f, st;
		logic [31:0] c;
		int n;
		f = 16'($urandom_range(1, 65535));
		st = 16'($urandom);
		c = {23'h0, 1'($urandom), 2'h0, s, 1'b0, m};
		wb(1'b1, `PLS_ADR_CTRL, c);
		wb(1'b1, `PLS_ADR_START, {16'h0, st});
		wb(1'b1, `PLS_ADR_OUTAGE, {22'h0, lim});
		dly <= d;
		dir <= s[0];
		run_want <= 1'b1;
		ofreq <= f;
		repeat (4) @(posedge clk_i);
		chk(out_en, 1'b1);
		pwr <= 1'b0;
		repeat (3) @(posedge clk_i);
		ofreq <= ~f;
		chk(out_en, 1'b0);
		chk(alarm, m == 3'h0);
		if (m == `PLS_MODE_RESUME) begin
			wb(1'b0, `PLS_ADR_LATCHED, 32'h0);
			chk(rd, {16'h0, f});
		end
		if (lim != 10'h0) begin
			wb(1'b0, `PLS_ADR_STATUS, 32'h0);
			chk(rd[2:0], (m == 3'h0) ? 3'h1 : 3'h2);
		end
		if (cs) begin
			coast <= 1'b1;
			@(posedge clk_i);
			coast <= 1'b0;
		end
		pwr <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(alarm, m < 3'h2);
		if (m > 3'h1 && lim != 10'h0 && !cs) begin
			wb(1'b0, `PLS_ADR_STATUS, 32'h0);
			chk(rd[2:0], 3'h3);
		end
		n = rcnt;
		for (int i = 0; i < 320 && rcnt == n; i++) @(posedge clk_i);
		chk(rcnt - n, ex);
		if (ex) begin
			chk(cap_s, (m == 3'h4) ? 2'h1 : 2'h2);
			chk(cap_f, (m == 3'h4) ? f : st);
			chk(cap_i, c[8]);
			chk(out_en, 1'b1);
		end else begin
			chk(fsel, 2'h0);
		end
		if (m < 3'h2) wb(1'b1, `PLS_ADR_CTRL, c | 32'h0001_0000);
		wb(1'b0, `PLS_ADR_INTSTAT, 32'h0);
		chk(rd, exp_int(m, ex));
		wb(1'b1, `PLS_ADR_INTMASK, 32'h0);
		chk(irq, 1'b0);
		wb(1'b1, `PLS_ADR_INTMASK, 32'hF);
		chk(irq, 1'b1);
		wb(1'b1, `PLS_ADR_INTSTAT, 32'hF);
		chk(irq, 1'b0);
		run_want <= 1'b0;
		coast <= 1'b1;
		repeat (2) @(posedge clk_i);
		coast <= 1'b0;
		dly <= 8'hFF;
		@(posedge clk_i);
	endtask : outage
	// ****************************************
	// Main sequence and watchdog.
	// ****************************************
	initial begin
		void'($urandom(12));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, `PLS_ADR_CTRL, 32'h0);
		chk(rd, `PLS_CTRL_RST);
		wb(1'b0, `PLS_ADR_START, 32'h0);
		chk(rd, `PLS_START_RST);
		wb(1'b0, `PLS_ADR_OUTAGE, 32'h0);
		chk(rd, `PLS_OUTAGE_RST);
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		pwr <= 1'b0;
		repeat (3) @(posedge clk_i);
		pwr <= 1'b1;
		chk(alarm, 1'b0);
		wb(1'b0, `PLS_ADR_STATUS, 32'h0);
		chk(rd[2:0], 3'h0);
		outage(3'h0, 2'h0, 8'hFF, 1'b0, 10'h3E7, 1'b0);
		outage(3'h1, 2'h0, 8'hFF, 1'b0, 10'h3E7, 1'b0);
		outage(3'h4, 2'h0, 8'($urandom_range(0, 180)), 1'b0, 10'h3E7, 1'b1);
		outage(3'h5, 2'h0, 8'hB4, 1'b0, 10'h3E7, 1'b1);
		outage(3'h4, 2'h2, 8'hFF, 1'b0, 10'h3E7, 1'b1);
		outage(3'h5, 2'h3, 8'hFF, 1'b0, 10'h3E7, 1'b1);
		outage(3'h4, 2'h0, 8'hFF, 1'b0, 10'h3E7, 1'b0);
		outage(3'h5, 2'h0, 8'h14, 1'b0, 10'h000, 1'b0);
		outage(3'h5, 2'h0, 8'h14, 1'b0, 10'h004, 1'b0);
		outage(3'h4, 2'h0, 8'h14, 1'b1, 10'h3E7, 1'b0);
		final_report();
	end
	initial begin
		#1000000;
		$display("BAD %0t watchdog expired", $time);
		errors++;
		final_report();
	end
endmodule : pls_restart_seq_tb
